//--- logic/dbg_pkg.sv
package dbg_pkg;
	localparam int DBG_DATA_W = 32;
	localparam int DBG_ADDR_W = 5;
	localparam int DBG_PORT_W = 8;
	// register byte addresses
	localparam logic [DBG_ADDR_W-1:0] DBG_OFF_P1_DIR = 5'h00;
	localparam logic [DBG_ADDR_W-1:0] DBG_OFF_P1_LATCH = 5'h04;
	localparam logic [DBG_ADDR_W-1:0] DBG_OFF_P1_READBACK = 5'h08;
	localparam logic [DBG_ADDR_W-1:0] DBG_OFF_P2_DIR = 5'h0C;
	localparam logic [DBG_ADDR_W-1:0] DBG_OFF_P2_LATCH = 5'h10;
	localparam logic [DBG_ADDR_W-1:0] DBG_OFF_P2_READBACK = 5'h14;
	localparam logic [DBG_PORT_W-1:0] DBG_DIR_RESET = 8'h00;
	localparam logic [DBG_PORT_W-1:0] DBG_LATCH_RESET = 8'h00;
	// value returned for a write-only register (undefined by the hardware)
	localparam logic [DBG_DATA_W-1:0] DBG_WO_READ_VALUE = 32'h00000000;
	localparam logic [1:0] DBG_RESP_OKAY = 2'h0;
	localparam logic [1:0] DBG_RESP_SLVERR = 2'h2;
	localparam int DBG_WORD_LSB = 2;
endpackage : dbg_pkg

//--- logic/dbg_gpio.sv
// Functional notes
// (R01) First port readback is read-only; writes are ignored.
// (R02) First port readback returns output latch bit where direction bit is 1.
// (R03) First port readback returns sampled pin level where direction bit is 0.
// (R04) First port pin is input when direction 0, output when 1.
// (R05) Second port has eight individually directed bidirectional pins.
// (R06) Second port direction register is write-only; reads give no stored value.
// (R07) Software writes whole bytes to direction registers, no read-modify-write.
// (R08) Second port direction 1 makes output; all direction bits reset to 0.
// (R09) Second port direction 0 makes the pin an input.
// (R10) Second port output latch is read/write, eight bits, reset to 0.
// (R11) Second port readback is read-only; writes are ignored.
// (R12) Second port readback returns latch bit where direction bit is 1.
// (R13) Second port readback returns pin level where direction bit is 0.
// (R14) Second port pin is input when direction 0, output when 1.
// (R15) First port direction register is write-only, reset 0, 1 means output.
// (R16) First port output latch is read/write, eight bits, reset to 0.
// (R17) Output pins driven continuously from latch; input pins undriven.
module dbg_gpio
	import dbg_pkg::*;
#(
	parameter int PORT_W = DBG_PORT_W
) (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic [dbg_pkg::DBG_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [dbg_pkg::DBG_DATA_W-1:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [dbg_pkg::DBG_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [dbg_pkg::DBG_DATA_W-1:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [PORT_W-1:0] first_port_pin_in,
	output logic [PORT_W-1:0] first_port_pin_out,
	output logic [PORT_W-1:0] first_port_pin_oe_out,
	input wire logic [PORT_W-1:0] second_port_pin_in,
	output logic [PORT_W-1:0] second_port_pin_out,
	output logic [PORT_W-1:0] second_port_pin_oe_out
);
	import dbg_pkg::*;

	function automatic logic [PORT_W-1:0] readback(input logic [PORT_W-1:0] dir, input logic [PORT_W-1:0] latch,
			input logic [PORT_W-1:0] pin);
		readback = (dir & latch) | (~dir & pin);
	endfunction : readback

	function automatic logic word_hit(input logic [DBG_ADDR_W-1:0] a, input logic [DBG_ADDR_W-1:0] off);
		word_hit = (a[DBG_ADDR_W-1:DBG_WORD_LSB] == off[DBG_ADDR_W-1:DBG_WORD_LSB]);
	endfunction : word_hit

	logic [PORT_W-1:0] first_port_direction;
	logic [PORT_W-1:0] first_port_output_latch;
	logic [PORT_W-1:0] second_port_direction;
	logic [PORT_W-1:0] second_port_output_latch;
	logic [PORT_W-1:0] next_first_port_direction;
	logic [PORT_W-1:0] next_first_port_output_latch;
	logic [PORT_W-1:0] next_second_port_direction;
	logic [PORT_W-1:0] next_second_port_output_latch;

	logic aw_held;
	logic w_held;
	logic [DBG_ADDR_W-1:0] aw_addr;
	logic [DBG_DATA_W-1:0] w_data;
	logic w_strb0;
	logic bvalid;
	logic [1:0] bresp;
	logic next_aw_held;
	logic next_w_held;
	logic [DBG_ADDR_W-1:0] next_aw_addr;
	logic [DBG_DATA_W-1:0] next_w_data;
	logic next_w_strb0;
	logic next_bvalid;
	logic [1:0] next_bresp;

	logic rvalid;
	logic [DBG_DATA_W-1:0] rdata;
	logic [1:0] rresp;
	logic next_rvalid;
	logic [DBG_DATA_W-1:0] next_rdata;
	logic [1:0] next_rresp;

	logic [PORT_W-1:0] first_port_readback;
	logic [PORT_W-1:0] second_port_readback;
	logic do_write;

	assign first_port_readback = readback(first_port_direction, first_port_output_latch, first_port_pin_in); // R02 R03
	assign second_port_readback = readback(second_port_direction, second_port_output_latch, second_port_pin_in); // R12 R13

	// pins: output enable follows direction, data follows latch
	assign first_port_pin_oe_out = first_port_direction; // R04 R17
	assign first_port_pin_out = first_port_output_latch; // R17
	assign second_port_pin_oe_out = second_port_direction; // R05 R14 R17
	assign second_port_pin_out = second_port_output_latch; // R17

	assign s_axi_awready_out = !aw_held && !bvalid;
	assign s_axi_wready_out = !w_held && !bvalid;
	assign s_axi_bvalid_out = bvalid;
	assign s_axi_bresp_out = bresp;
	assign s_axi_arready_out = !rvalid;
	assign s_axi_rvalid_out = rvalid;
	assign s_axi_rdata_out = rdata;
	assign s_axi_rresp_out = rresp;
	assign do_write = aw_held && w_held && !bvalid;

	// write path: address and data held in either order, applied together
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb0 = w_strb0;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_first_port_direction = first_port_direction;
		next_first_port_output_latch = first_port_output_latch;
		next_second_port_direction = second_port_direction;
		next_second_port_output_latch = second_port_output_latch;
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata_in;
			next_w_strb0 = s_axi_wstrb_in[0];
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = DBG_RESP_OKAY;
			if (word_hit(aw_addr, DBG_OFF_P1_DIR)) begin
				if (w_strb0) begin
					next_first_port_direction = w_data[PORT_W-1:0]; // R15
				end
			end else if (word_hit(aw_addr, DBG_OFF_P1_LATCH)) begin
				if (w_strb0) begin
					next_first_port_output_latch = w_data[PORT_W-1:0]; // R16
				end
			end else if (word_hit(aw_addr, DBG_OFF_P2_DIR)) begin
				if (w_strb0) begin
					next_second_port_direction = w_data[PORT_W-1:0]; // R08 R09
				end
			end else if (word_hit(aw_addr, DBG_OFF_P2_LATCH)) begin
				if (w_strb0) begin
					next_second_port_output_latch = w_data[PORT_W-1:0]; // R10
				end
			end else if (word_hit(aw_addr, DBG_OFF_P1_READBACK) || word_hit(aw_addr, DBG_OFF_P2_READBACK)) begin
				next_bresp = DBG_RESP_OKAY; // R01 R11
			end else begin
				next_bresp = DBG_RESP_SLVERR;
			end
		end
		if (bvalid && s_axi_bready_in) begin
			next_bvalid = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb0 <= 1'b0;
			bvalid <= 1'b0;
			bresp <= DBG_RESP_OKAY;
			first_port_direction <= DBG_DIR_RESET; // R15
			first_port_output_latch <= DBG_LATCH_RESET; // R16
			second_port_direction <= DBG_DIR_RESET; // R08
			second_port_output_latch <= DBG_LATCH_RESET; // R10
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb0 <= next_w_strb0;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			first_port_direction <= next_first_port_direction;
			first_port_output_latch <= next_first_port_output_latch;
			second_port_direction <= next_second_port_direction;
			second_port_output_latch <= next_second_port_output_latch;
		end
	end

	// read path: registers and pins sampled at the accepting edge
	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && s_axi_rready_in) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			next_rvalid = 1'b1;
			next_rresp = DBG_RESP_OKAY;
			next_rdata = '0;
			if (word_hit(s_axi_araddr_in, DBG_OFF_P1_DIR) || word_hit(s_axi_araddr_in, DBG_OFF_P2_DIR)) begin
				next_rdata = DBG_WO_READ_VALUE; // R06 R15
			end else if (word_hit(s_axi_araddr_in, DBG_OFF_P1_LATCH)) begin
				next_rdata[PORT_W-1:0] = first_port_output_latch; // R16
			end else if (word_hit(s_axi_araddr_in, DBG_OFF_P2_LATCH)) begin
				next_rdata[PORT_W-1:0] = second_port_output_latch; // R10
			end else if (word_hit(s_axi_araddr_in, DBG_OFF_P1_READBACK)) begin
				next_rdata[PORT_W-1:0] = first_port_readback; // R02 R03
			end else if (word_hit(s_axi_araddr_in, DBG_OFF_P2_READBACK)) begin
				next_rdata[PORT_W-1:0] = second_port_readback; // R12 R13
			end else begin
				next_rresp = DBG_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= DBG_RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// assertions
	AST_P1_OE_DIR: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R04
		first_port_pin_oe_out == first_port_direction)
		else $error("first port enable differs from direction");
	AST_P2_OE_DIR: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R14
		second_port_pin_oe_out == second_port_direction)
		else $error("second port enable differs from direction");
	AST_PIN_DRIVE: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R17
		(first_port_pin_out == first_port_output_latch) && (second_port_pin_out == second_port_output_latch))
		else $error("pin data differs from latch");
	AST_P1_RB: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R02
		s_axi_arvalid_in && s_axi_arready_out && word_hit(s_axi_araddr_in, DBG_OFF_P1_READBACK)
		|=> s_axi_rdata_out[PORT_W-1:0] == (($past(first_port_direction) & $past(first_port_output_latch))
			| (~$past(first_port_direction) & $past(first_port_pin_in))))
		else $error("first port readback wrong");
	AST_P1_RB_IN: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R03
		s_axi_arvalid_in && s_axi_arready_out && word_hit(s_axi_araddr_in, DBG_OFF_P1_READBACK)
		&& first_port_direction == '0 |=> s_axi_rdata_out[PORT_W-1:0] == $past(first_port_pin_in))
		else $error("first port input readback wrong");
	AST_P2_RB: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R12
		s_axi_arvalid_in && s_axi_arready_out && word_hit(s_axi_araddr_in, DBG_OFF_P2_READBACK)
		|=> (s_axi_rdata_out[PORT_W-1:0] & $past(second_port_direction))
			== ($past(second_port_output_latch) & $past(second_port_direction)))
		else $error("second port output readback wrong");
	AST_P2_RB_IN: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R13
		s_axi_arvalid_in && s_axi_arready_out && word_hit(s_axi_araddr_in, DBG_OFF_P2_READBACK)
		&& second_port_direction == '0 |=> s_axi_rdata_out[PORT_W-1:0] == $past(second_port_pin_in))
		else $error("second port input readback wrong");
	AST_P2_DIR_WR: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R08
		do_write && w_strb0 && word_hit(aw_addr, DBG_OFF_P2_DIR)
		|=> second_port_pin_oe_out == $past(w_data[PORT_W-1:0]) && s_axi_bvalid_out)
		else $error("second port direction write not applied");
	AST_RO_NOCHG: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R01
		do_write && (word_hit(aw_addr, DBG_OFF_P1_READBACK) || word_hit(aw_addr, DBG_OFF_P2_READBACK))
		|=> $stable(first_port_direction) && $stable(first_port_output_latch)
			&& $stable(second_port_direction) && $stable(second_port_output_latch))
		else $error("readback write changed state");
	AST_WO_READ: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R06
		s_axi_arvalid_in && s_axi_arready_out && word_hit(s_axi_araddr_in, DBG_OFF_P2_DIR)
		|=> s_axi_rdata_out == DBG_WO_READ_VALUE)
		else $error("direction register readable");
	AST_P1_LATCH_WR: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R16
		do_write && w_strb0 && word_hit(aw_addr, DBG_OFF_P1_LATCH)
		|=> ##1 first_port_pin_out == $past(w_data[PORT_W-1:0], 2))
		else $error("first port latch write lost");

	// write-side checks
	AST_P1_DIR_WR: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R15
		do_write && w_strb0 && word_hit(aw_addr, DBG_OFF_P1_DIR)
		|=> first_port_pin_oe_out == $past(w_data[PORT_W-1:0]))
		else $error("first port direction write not applied");
	AST_P1_DIR_IN: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R04
		do_write && w_strb0 && word_hit(aw_addr, DBG_OFF_P1_DIR)
		|=> (first_port_pin_oe_out & ~$past(w_data[PORT_W-1:0])) == '0)
		else $error("first port input pin still driven");
	AST_P2_DIR_IN: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R09
		do_write && w_strb0 && word_hit(aw_addr, DBG_OFF_P2_DIR)
		|=> (second_port_pin_oe_out & ~$past(w_data[PORT_W-1:0])) == '0)
		else $error("second port input pin still driven");
	AST_P2_LATCH_WR: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R10
		do_write && w_strb0 && word_hit(aw_addr, DBG_OFF_P2_LATCH)
		|=> second_port_pin_out == $past(w_data[PORT_W-1:0]))
		else $error("second port latch write lost");
	AST_STRB_LOW: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R16
		do_write && !w_strb0
		|=> $stable(first_port_direction) && $stable(first_port_output_latch)
			&& $stable(second_port_direction) && $stable(second_port_output_latch))
		else $error("write without low byte strobe changed state");
	AST_RB_WR_OKAY: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R11
		do_write && (word_hit(aw_addr, DBG_OFF_P1_READBACK) || word_hit(aw_addr, DBG_OFF_P2_READBACK))
		|=> s_axi_bvalid_out && s_axi_bresp_out == DBG_RESP_OKAY)
		else $error("readback write not acknowledged");

	// read-side checks
	AST_P1_WO_READ: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R15
		s_axi_arvalid_in && s_axi_arready_out && word_hit(s_axi_araddr_in, DBG_OFF_P1_DIR)
		|=> s_axi_rdata_out == DBG_WO_READ_VALUE)
		else $error("first direction register readable");
	AST_P1_LATCH_RD: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R16
		s_axi_arvalid_in && s_axi_arready_out && word_hit(s_axi_araddr_in, DBG_OFF_P1_LATCH)
		|=> s_axi_rdata_out[PORT_W-1:0] == $past(first_port_output_latch))
		else $error("first port latch read wrong");
	AST_P2_LATCH_RD: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R10
		s_axi_arvalid_in && s_axi_arready_out && word_hit(s_axi_araddr_in, DBG_OFF_P2_LATCH)
		|=> s_axi_rdata_out[PORT_W-1:0] == $past(second_port_output_latch))
		else $error("second port latch read wrong");

	// reset and idle pin checks
	AST_RST_CLEAR: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R08
		$rose(reset_n_in) |-> second_port_pin_oe_out == '0 && first_port_pin_oe_out == '0
			&& second_port_pin_out == '0 && first_port_pin_out == '0)
		else $error("pins not cleared by reset");
	AST_PIN_HOLD: assert property (@(posedge core_clk_in) disable iff (!reset_n_in) // R17
		!do_write |=> $stable(first_port_pin_out) && $stable(first_port_pin_oe_out)
			&& $stable(second_port_pin_out) && $stable(second_port_pin_oe_out))
		else $error("pins changed without a write");

	// coverage
	COV_WRITE: cover property (@(posedge core_clk_in) disable iff (!reset_n_in) s_axi_bvalid_out && s_axi_bready_in);
	COV_READ_RB: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
		s_axi_arvalid_in && s_axi_arready_out && word_hit(s_axi_araddr_in, DBG_OFF_P2_READBACK));
	COV_MIXED_DIR: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
		first_port_direction != '0 && first_port_direction != '1);
	COV_SLVERR: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
		s_axi_bvalid_out && s_axi_bresp_out == DBG_RESP_SLVERR);
	COV_P2_DRIVE: cover property (@(posedge core_clk_in) disable iff (!reset_n_in)
		second_port_pin_oe_out != '0 && second_port_pin_out != '0);
endmodule : dbg_gpio

//--- testbench/dbg_pin_partner.sv
module dbg_pin_partner
	import dbg_pkg::*;
(
	input wire logic [dbg_pkg::DBG_PORT_W-1:0] ext_level_in,
	input wire logic [dbg_pkg::DBG_PORT_W-1:0] drive_in,
	input wire logic [dbg_pkg::DBG_PORT_W-1:0] oe_in,
	output logic [dbg_pkg::DBG_PORT_W-1:0] pin_level_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import dbg_pkg::*;
	// driven bits follow the device, released bits the outside world
	assign pin_level_out = (oe_in & drive_in) | (~oe_in & ext_level_in);
endmodule : dbg_pin_partner

//--- testbench/test_dual_byte_gpio_ports.sv
module test_dual_byte_gpio_ports;
	timeunit 1ns;
	timeprecision 1ns;
	import dbg_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] ext1 = '0, ext2 = '0, lvl1, lvl2, out1, oe1, out2, oe2;
	int dir1 = 0, lat1 = 0, dir2 = 0, lat2 = 0;
	int miscompares = 0;
	int samples_checked = 0;
	always #10 clk = ~clk;
	dbg_gpio dbg_gpio_inst (.core_clk_in(clk), .reset_n_in(rst_n),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.first_port_pin_in(lvl1), .first_port_pin_out(out1), .first_port_pin_oe_out(oe1),
		.second_port_pin_in(lvl2), .second_port_pin_out(out2), .second_port_pin_oe_out(oe2));
	dbg_pin_partner first_pins (.ext_level_in(ext1), .drive_in(out1), .oe_in(oe1), .pin_level_out(lvl1));
	dbg_pin_partner second_pins (.ext_level_in(ext2), .drive_in(out2), .oe_in(oe2), .pin_level_out(lvl2));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	task automatic cmp_bus(input string what, input logic [33:0] exp, input logic [33:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_bus
	task automatic cmp_pin(input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch pins expected %h seen %h", exp, got);
		end
	endtask : cmp_pin
	function automatic logic [33:0] model_read(input logic [4:0] a);
		logic [7:0] d1, d2, l1, l2;
		d1 = dir1[7:0];
		d2 = dir2[7:0];
		l1 = lat1[7:0];
		l2 = lat2[7:0];
		case (a)
			DBG_OFF_P1_DIR, DBG_OFF_P2_DIR: return {DBG_RESP_OKAY, DBG_WO_READ_VALUE};
			DBG_OFF_P1_LATCH: return {DBG_RESP_OKAY, 24'h000000, l1};
			DBG_OFF_P2_LATCH: return {DBG_RESP_OKAY, 24'h000000, l2};
			DBG_OFF_P1_READBACK: return {DBG_RESP_OKAY, 24'h000000, (d1 & l1) | (~d1 & ext1)};
			DBG_OFF_P2_READBACK: return {DBG_RESP_OKAY, 24'h000000, (d2 & l2) | (~d2 & ext2)};
			default: return {DBG_RESP_SLVERR, 32'h00000000};
		endcase
	endfunction : model_read
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw_hit, w_hit, b_hit;
		int n;
		b_hit = 0;
		if (s[0] && a == DBG_OFF_P1_DIR) dir1 = d[7:0];
		if (s[0] && a == DBG_OFF_P1_LATCH) lat1 = d[7:0];
		if (s[0] && a == DBG_OFF_P2_DIR) dir2 = d[7:0];
		if (s[0] && a == DBG_OFF_P2_LATCH) lat2 = d[7:0];
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 50 && !b_hit; n++) begin
			@(negedge clk);
			aw_hit = awvalid && awready;
			w_hit = wvalid && wready;
			b_hit = bvalid;
			if (b_hit) begin
				cmp_bus("bresp", {a <= DBG_OFF_P2_READBACK ? DBG_RESP_OKAY : DBG_RESP_SLVERR, 32'h0}, {bresp, 32'h0});
				cmp_pin({dir2[7:0], dir1[7:0], lat2[7:0], lat1[7:0]}, {oe2, oe1, out2, out1});
			end
			@(posedge clk);
			if (aw_hit) awvalid <= 0;
			if (w_hit) wvalid <= 0;
			if (b_hit) bready <= 0;
		end
		if (!b_hit) miscompares++;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [4:0] a);
		logic ar_hit, r_hit;
		int n;
		r_hit = 0;
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 50 && !r_hit; n++) begin
			@(negedge clk);
			ar_hit = arvalid && arready;
			r_hit = rvalid;
			if (r_hit) cmp_bus("read", model_read(a), {rresp, rdata});
			@(posedge clk);
			if (ar_hit) arvalid <= 0;
			if (r_hit) rready <= 0;
		end
		if (!r_hit) miscompares++;
		@(posedge clk);
	endtask : rd
	initial begin
		#(20 * 10000);
		miscompares++;
		end_sim();
	end
	initial begin
		void'($urandom(32'hE7C65F7C));
		ext1 <= 8'hA5;
		ext2 <= 8'h3C;
		repeat (16) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		for (int a = 0; a < 32; a += 4) rd(a[4:0]);
		for (int i = 0; i < 250; i++) begin
			ext1 <= $urandom;
			ext2 <= $urandom;
			wr({$urandom_range(0, 6), 2'b00}, $urandom, $urandom_range(0, 3) == 0 ? 4'h0 : 4'hF);
			rd(DBG_OFF_P1_READBACK);
			rd(DBG_OFF_P2_READBACK);
			rd({$urandom_range(0, 7), 2'b00});
		end
		rst_n <= 0;
		dir1 = 0;
		lat1 = 0;
		dir2 = 0;
		lat2 = 0;
		@(negedge clk);
		cmp_pin(32'h00000000, {oe2, oe1, out2, out1});
		@(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		for (int a = 0; a < 32; a += 4) rd(a[4:0]);
		end_sim();
	end
endmodule : test_dual_byte_gpio_ports
